//--- src/cpdm_mapper.sv
// Summary of operation
// R1: Every commutated axis lowers the configured standard axis count by one.
// R2: Freed axes stop being independent axes and their DACs only carry second phases.
// R3: A selection that includes the highest axis is never accepted.
// R4: A commutated axis drives its first phase on its own DAC.
// R5: A single commutated axis drives its second phase on the highest freed DAC.
// R6: Second phases go to freed DACs in matching order, lowest axis to lowest freed DAC.
// R7: Axis A is the lowest axis and the top of the configured count is the highest.
// R8: Each accepted selection recomputes the whole mapping and replaces the old one.
module cpdm_mapper
  import cpdm_pkg::*;
#(
  parameter int  NUM_AXES = CPDM_AXES_DEF,
  parameter int  DAC_W    = CPDM_DAC_W_DEF,
  localparam int CW       = $clog2(NUM_AXES + 1),
  localparam int IW       = $clog2(NUM_AXES)
) (
  // Clock and reset
  input  wire logic                             mclk,
  input  wire logic                             resetn,
  // Selection from the command interpreter
  input  wire logic                             sel_valid,
  input  wire logic [NUM_AXES-1:0]              sel_mask,
  // Per-axis commands from the servo loops
  input  wire logic [NUM_AXES-1:0][DAC_W-1:0]   phase1_cmd,
  input  wire logic [NUM_AXES-1:0][DAC_W-1:0]   phase2_cmd,
  // DAC channels
  output logic      [NUM_AXES-1:0][DAC_W-1:0]   dac_out,
  // Configuration state
  output logic      [NUM_AXES-1:0]              comm_mask,
  output logic      [NUM_AXES-1:0]              freed_mask,
  output logic      [NUM_AXES-1:0]              std_mask,
  output logic      [CW-1:0]                    axis_count,
  output cpdm_resp_type                         sel_resp
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NUM_AXES < 2 || NUM_AXES > CPDM_AXES_MAX) begin : g_bad_axes
    $error("NUM_AXES out of range");
  end
  if (DAC_W < 1) begin : g_bad_width
    $error("DAC_W must be positive");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [CW-1:0] count_ones(input logic [NUM_AXES-1:0] m);
    logic [CW-1:0] c;
    c = '0;
    for (int i = 0; i < NUM_AXES; i++) begin
      c = c + CW'(m[i]);
    end
    return c;
  endfunction

  // Number of selected axes below idx; axis A is index zero
  function automatic logic [CW-1:0] rank_of(input logic [NUM_AXES-1:0] m,
                                            input logic [IW-1:0]       idx);
    logic [CW-1:0] c;
    c = '0;
    for (int i = 0; i < NUM_AXES; i++) begin
      if (i < int'(idx)) begin
        c = c + CW'(m[i]);
      end
    end
    return c;
  endfunction

  // Axis whose second phase lands on DAC d
  function automatic logic [IW-1:0] src_for(input logic [NUM_AXES-1:0] m,
                                            input logic [CW-1:0]       base,
                                            input int                  d);
    logic [IW-1:0] s;
    s = '0;
    for (int i = 0; i < NUM_AXES; i++) begin
      if (m[i] && (int'(base) + int'(rank_of(m, IW'(i))) == d)) begin
        s = IW'(i);
      end
    end
    return s;
  endfunction

  function automatic logic [IW-1:0] first_one(input logic [NUM_AXES-1:0] m);
    logic [IW-1:0] s;
    s = '0;
    for (int i = NUM_AXES - 1; i >= 0; i--) begin
      if (m[i]) begin
        s = IW'(i);
      end
    end
    return s;
  endfunction

  // ----------------------------------------------------------------
  // Selection decode
  // ----------------------------------------------------------------
  logic [NUM_AXES-1:0]         comm_r;
  logic [CW-1:0]               base_r;
  logic [NUM_AXES-1:0][IW-1:0] src_r;
  logic [NUM_AXES-1:0][IW-1:0] src_nxt;
  logic [NUM_AXES-1:0][DAC_W-1:0] dac_nxt;
  logic [NUM_AXES-1:0]         hi_hit;
  logic [NUM_AXES-1:0]         freed_nxt;
  logic [NUM_AXES-1:0]         std_nxt;
  cpdm_resp_type               resp_r;

  wire [CW-1:0] sel_cnt  = count_ones(sel_mask);
  // R1: configured count is the full count less the commutated axes
  wire [CW-1:0] sel_base = CW'(NUM_AXES) - sel_cnt;                       // R1
  wire          top_req  = sel_mask[NUM_AXES-1];                          // R3
  // A commutated axis may not sit in the freed range, since its own DAC would
  // then be owed to two phases; such selections are refused whole.
  wire          clash    = |hi_hit;                                       // R2
  wire          accept   = sel_valid && !top_req && !clash;               // R3
  wire          refuse   = sel_valid && !accept;

  for (genvar d = 0; d < NUM_AXES; d++) begin : g_dac
    assign hi_hit[d]    = sel_mask[d] && (d >= int'(sel_base));           // R7
    assign src_nxt[d]   = src_for(sel_mask, sel_base, d);                 // R6
    assign freed_nxt[d] = d >= int'(base_r);                              // R2
    assign std_nxt[d]   = !freed_nxt[d] && !comm_r[d];
    // R4: own DAC keeps the first phase; freed DACs take second phases
    assign dac_nxt[d]   = freed_nxt[d] ? phase2_cmd[src_r[d]]             // R5
                                       : phase1_cmd[d];                   // R4
  end

  // ----------------------------------------------------------------
  // Mapping registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      comm_r <= '0;
      base_r <= CW'(NUM_AXES);
      src_r  <= '0;
    end else if (accept) begin
      comm_r <= sel_mask;                                                 // R8
      base_r <= sel_base;                                                 // R1
      src_r  <= src_nxt;                                                  // R6
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      resp_r <= '{done: CPDM_RESP_RST, reject: CPDM_RESP_RST};
    end else begin
      resp_r <= '{done: accept, reject: refuse};                          // R3
    end
  end

  // Outputs lag the mapping by one cycle so every DAC changes on one edge
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      dac_out    <= '0;
      freed_mask <= '0;
      std_mask   <= '1;
    end else begin
      dac_out    <= dac_nxt;
      freed_mask <= freed_nxt;
      std_mask   <= std_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      comm_mask  <= '0;
      axis_count <= CW'(NUM_AXES);
    end else begin
      comm_mask  <= comm_r;
      axis_count <= base_r;
    end
  end

  assign sel_resp = resp_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [NUM_AXES-1:0][DAC_W-1:0] p1_q;
  logic [NUM_AXES-1:0][DAC_W-1:0] p2_q;
  // Source table aligned with dac_out, since src_r leads the outputs by one cycle
  logic [NUM_AXES-1:0][IW-1:0]    src_q;

  always_ff @(posedge mclk) begin
    p1_q  <= phase1_cmd;
    p2_q  <= phase2_cmd;
    src_q <= src_r;
  end

  sequence s_take;
    accept;
  endsequence

  sequence s_shown(logic [NUM_AXES-1:0] m);
    ##2 comm_mask == $past(m, 2);
  endsequence

  count_drop_a: assert property (@(posedge mclk) disable iff (!resetn) // R1
    s_take |-> ##2 (int'(axis_count) == NUM_AXES - int'(count_ones($past(sel_mask, 2)))))
    else $error("axis count did not drop by the commutated axes");

  freed_only_a: assert property (@(posedge mclk) disable iff (!resetn) // R2
    ((freed_mask & (comm_mask | std_mask)) == '0))
    else $error("freed DAC still serves as an axis");

  top_refused_a: assert property (@(posedge mclk) disable iff (!resetn) // R3
    (sel_valid && top_req) |=> sel_resp.reject ##1 !comm_mask[NUM_AXES-1])
    else $error("highest axis accepted for commutation");

  recompute_a: assert property (@(posedge mclk) disable iff (!resetn) // R8
    s_take |-> s_shown(sel_mask))
    else $error("mapping not replaced by new selection");

  count_sum_a: assert property (@(posedge mclk) disable iff (!resetn) // R7
    int'(axis_count) + int'(count_ones(comm_mask)) == NUM_AXES)
    else $error("axis count and commutated set disagree");

  single_top_a: assert property (@(posedge mclk) disable iff (!resetn) // R5
    (count_ones(comm_mask) == CW'(1) && $stable(comm_mask))
      |-> dac_out[NUM_AXES-1] == p2_q[first_one(comm_mask)])
    else $error("single second phase not on highest DAC");

  for (genvar d = 0; d < NUM_AXES; d++) begin : g_chk
    phase_one_a: assert property (@(posedge mclk) disable iff (!resetn) // R4
      (d < int'(base_r)) |=> dac_out[d] == p1_q[d])
      else $error("own DAC does not carry first phase");

    order_a: assert property (@(posedge mclk) disable iff (!resetn) // R6
      (freed_mask[d] && $stable(comm_mask))
        |-> (comm_mask[src_q[d]]
             && int'(rank_of(comm_mask, src_q[d])) == d - int'(axis_count)
             && dac_out[d] == p2_q[src_q[d]]))
      else $error("second phase on wrong freed DAC");
  end

endmodule

//--- src/cpdm_pkg.sv
package cpdm_pkg;

  // ----------------------------------------------------------------
  // Defaults and limits
  // ----------------------------------------------------------------
  localparam int CPDM_AXES_DEF  = 8;
  localparam int CPDM_AXES_MAX  = 16;
  localparam int CPDM_DAC_W_DEF = 16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic CPDM_RESP_RST = 1'b0;

  // ----------------------------------------------------------------
  // Selection answer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic done;
    logic reject;
  } cpdm_resp_type;

endpackage

//--- testbench/cpdm_dac_bank.sv
// ----------------------------------------------------------------
// DAC channels at the amplifier side
// ----------------------------------------------------------------
// A DAC takes a new code on every rising edge and never stalls, so it holds
// the latest code only.
module cpdm_dac_bank #(
  parameter int N = 8
) (
  // Clock
  input wire logic                 mclk,
  // Codes from the mapper
  input wire logic [N-1:0][15:0]   dac_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [N-1:0][15:0] held_r;
  always @(posedge mclk) held_r <= dac_out;
endmodule

//--- testbench/cpdm_mapper_tb.sv
module cpdm_mapper_tb
  import cpdm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 8;
  logic               mclk = 1'b0;
  logic               resetn = 1'b0;
  logic               sel_valid = 1'b0;
  logic [N-1:0]       sel_mask = '0;
  logic [N-1:0][15:0] p1 = '0;
  logic [N-1:0][15:0] p2 = '0;
  logic [N-1:0][15:0] dac_out;
  logic [N-1:0]       comm_mask;
  logic [N-1:0]       freed_mask;
  logic [N-1:0]       std_mask;
  logic [3:0]         axis_count;
  cpdm_resp_type      sel_resp;
  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  logic [31:0]        lfsr_r = 32'h0001_5304;
  logic [N-1:0]       m_comm = '0;
  logic [N-1:0]       nxt = '0;
  logic [N-1:0][15:0] e_dac = '0;
  cpdm_resp_type      e_resp = '0;
  int                 m_cnt = N;
  bit                 pend = 1'b0;
  int                 num_errors = 0;
  int                 samples_checked = 0;
  logic [7:0]         tbl [8] = '{8'h05, 8'h01, 8'h80, 8'h41, 8'h00, 8'h07, 8'h03, 8'h0C};

  cpdm_mapper #(.NUM_AXES(N), .DAC_W(16)) dut_u (
    .mclk(mclk), .resetn(resetn), .sel_valid(sel_valid), .sel_mask(sel_mask),
    .phase1_cmd(p1), .phase2_cmd(p2), .dac_out(dac_out), .comm_mask(comm_mask),
    .freed_mask(freed_mask), .std_mask(std_mask), .axis_count(axis_count),
    .sel_resp(sel_resp));
  cpdm_dac_bank #(.N(N)) dac_u (.mclk(mclk), .dac_out(dac_out));

  always #25 mclk = ~mclk;

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Rank j of the commutated axes lands on DAC count + j
  function automatic logic [N-1:0][15:0] f_dac(logic [N-1:0] cm, int cnt);
    int j;
    f_dac = p1;
    j = 0;
    for (int i = 0; i < N; i++) if (cm[i]) begin
      f_dac[cnt + j] = p2[i];
      j++;
    end
  endfunction

  task automatic cmp_dac(input logic [N-1:0][15:0] got, input logic [N-1:0][15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t dac got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_cfg(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Check the last cycle, then drive fresh commands and a selection
  task automatic step(input logic v, input logic [N-1:0] m);
    logic [N-1:0] fr;
    int pc;
    @(negedge mclk);
    fr = {N{1'b1}} << m_cnt;
    cmp_dac(dac_out, e_dac);
    cmp_cfg({comm_mask, freed_mask, std_mask, axis_count},
            {m_comm, fr, ~(m_comm | fr), m_cnt[3:0]}, "map");
    cmp_cfg(sel_resp, e_resp, "resp");
    if (pend) m_comm = nxt;
    m_cnt = N - $countones(m_comm);
    pend = 1'b0;
    for (int i = 0; i < N; i++) begin
      lfsr_r = lfsr(lfsr_r);
      p1[i] = lfsr_r[15:0];
      p2[i] = lfsr_r[31:16];
    end
    sel_valid = v;
    sel_mask = m;
    e_dac = f_dac(m_comm, m_cnt);
    pc = $countones(m);
    e_resp = '0;
    if (v) begin
      e_resp.done = (m >> (N - pc)) == '0;
      e_resp.reject = !e_resp.done;
      pend = e_resp.done;
      nxt = m;
    end
  endtask

  // Mid-run reset: outputs return to reset values and the mapping is lost
  task automatic pulse_reset;
    @(negedge mclk);
    resetn = 1'b0;
    sel_valid = 1'b0;
    sel_mask = '0;
    m_comm = '0;
    m_cnt = N;
    pend = 1'b0;
    e_resp = '0;
    repeat (2) @(negedge mclk);
    cmp_dac(dac_out, '0);
    cmp_cfg({comm_mask, freed_mask, std_mask, axis_count},
            {{N{1'b0}}, {N{1'b0}}, {N{1'b1}}, 4'(N)}, "rst");
    cmp_cfg(sel_resp, '0, "rst resp");
    resetn = 1'b1;
    e_dac = p1;
  endtask

  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'b1;
    step(1'b0, '0);
    $display("test reset done");
    foreach (tbl[i]) begin
      step(1'b1, tbl[i]);
      step(1'b0, '0);
      step(1'b0, '0);
    end
    $display("test table done");
    step(1'b1, 8'h03);
    step(1'b1, 8'h0C);
    step(1'b1, 8'h80);
    repeat (3) step(1'b0, '0);
    $display("test back to back done");
    pulse_reset();
    step(1'b1, 8'h05);
    repeat (3) step(1'b0, '0);
    $display("test mid reset done");
    repeat (40) begin
      step(1'b1, lfsr_r[7:0] & lfsr_r[15:8]);
      step(1'b0, '0);
      step(1'b0, '0);
    end
    $display("test random done");
    print_verdict();
  end
endmodule
